// >>> pcrs_pkg.sv
// Behaviour
// R1: 21-bit byte counter spans two megabytes
// R2: Fetch beyond implemented memory returns zeros
// R3: Reset loads 0000h; interrupts vector 0008h/0018h
// R4: Only low byte visible; upper via latches
// R5: Low byte write loads both latches
// R6: Low byte read copies upper bytes
// R7: Bit zero fixed; sequential step is two
// R8: Calls, jumps, branches load counter directly
// R9: Push on calls/interrupts; pop on returns
// R10: Calls and returns leave latches alone
// R11: 31 by 21-bit stack, 5-bit pointer
// R12: Push increments first; pop decrements after
// R13: Resets clear pointer; slot zero empty
// R14: Top entry registers access pointed slot
// R15: Pointer readable and writable 0 to 31
// R16: Full flag after 31 pushes, software clear
// R17: Overflow reset stores value, resets, pointer zero
// R18: No overflow reset: pointer stays at 31
// R19: Empty pop loads zero, sets underflow
// R20: Overflow-reset bit selects reset after flag
// R21: Explicit push stores; explicit pop discards
// R22: Pointer register layout: full, underflow, pointer
// R23: Software masks interrupts during stack edits
// R24: Flag writes can only clear
package pcrs_pkg;
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam logic [SP_W-1:0] SP_MAX = 5'h1F;
    localparam logic [SP_W-1:0] SP_RST = 5'h00;
    localparam logic [PC_W-1:0] VEC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] VEC_INT_HI = 21'h000008;
    localparam logic [PC_W-1:0] VEC_INT_LO = 21'h000018;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W:0] MEM_BYTES_DEF = 22'h020000;
    // Register byte addresses
    localparam logic [7:0] OFS_CNT_LOW = 8'h00;
    localparam logic [7:0] OFS_HIGH_LATCH = 8'h04;
    localparam logic [7:0] OFS_UPPER_LATCH = 8'h08;
    localparam logic [7:0] OFS_TOP_LOW = 8'h0C;
    localparam logic [7:0] OFS_TOP_HIGH = 8'h10;
    localparam logic [7:0] OFS_TOP_UPPER = 8'h14;
    localparam logic [7:0] OFS_STACK_PTR = 8'h18;
    // Pointer register fields
    localparam int BIT_FULL = 7;
    localparam int BIT_UNF = 6;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_SEQ = 4'h1,
        OP_CALL = 4'h2,
        OP_RELATIVE_SUBROUTINE_JUMP = 4'h3,
        OP_JUMP = 4'h4,
        OP_BRANCH = 4'h5,
        OP_INT_HI = 4'h6,
        OP_INT_LO = 4'h7,
        OP_RETURN = 4'h8,
        OP_RET_LIT = 4'h9,
        OP_RET_INT = 4'hA,
        OP_UNLINK = 4'hB,
        OP_PUSH = 4'hC,
        OP_POP = 4'hD
    } pcrs_op_t;

    typedef struct packed {
        pcrs_op_t op;
        logic [PC_W-1:0] target;
    } pcrs_cmd_t;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [7:0] high_latch;
        logic [4:0] upper_latch;
        logic [SP_W-1:0] sp;
        logic full;
        logic unf;
        logic [31:1][PC_W-1:0] stk;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic dev_rst;
        logic [15:0] instr;
    } pcrs_state_t;
endpackage

// >>> pcrs_top.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module pcrs_top #(
    parameter logic [21:0] MEM_BYTES = pcrs_pkg::MEM_BYTES_DEF
) (
    input wire logic I_MCLK,                  // Core clock, 50 MHz
    input wire logic I_RESET,                 // Power-on reset, async high
    input wire logic I_DEV_RESET,             // Other device resets, sync
    input wire logic I_OVF_RST_EN,            // Overflow-reset config bit
    input wire logic I_EXT_EN,                // Extended set enabled
    input wire pcrs_pkg::pcrs_cmd_t I_CMD,    // Sequencer command
    input wire logic [15:0] I_PROG_DATA,      // Program memory word
    input wire logic I_PSEL,                  // APB select
    input wire logic I_PENABLE,               // APB enable
    input wire logic I_PWRITE,                // APB direction
    input wire logic [7:0] I_PADDR,           // APB byte address
    input wire logic [31:0] I_PWDATA,         // APB write data
    input wire logic [3:0] I_PSTRB,           // APB byte strobes
    output logic O_PREADY,                    // APB ready
    output logic O_PSLVERR,                   // APB error, unmapped
    output logic [31:0] O_PRDATA,             // APB read data
    output logic [20:0] O_FETCH_ADDR,         // Counter, fetch address
    output logic [15:0] O_INSTR,              // Fetched word
    output logic O_STACK_RESET,               // Stack reset pulse
    output logic O_FULL,                      // Stack full flag
    output logic O_UNF                        // Stack underflow flag
);
    import pcrs_pkg::*;

    pcrs_state_t st_r;
    pcrs_state_t st_nxt;

    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input pcrs_state_t s);
        logic [PC_W-1:0] top_entry;
        top_entry = (s.sp == SP_RST) ? '0 : s.stk[s.sp];
        rd_word = '0;
        if (a == OFS_CNT_LOW) begin
            rd_word[7:0] = s.pc[7:0];
        end else if (a == OFS_HIGH_LATCH) begin
            rd_word[7:0] = s.high_latch;
        end else if (a == OFS_UPPER_LATCH) begin
            rd_word[4:0] = s.upper_latch;
        end else if (a == OFS_TOP_LOW) begin
            rd_word[7:0] = top_entry[7:0]; // R14
        end else if (a == OFS_TOP_HIGH) begin
            rd_word[7:0] = top_entry[15:8]; // R14
        end else if (a == OFS_TOP_UPPER) begin
            rd_word[4:0] = top_entry[20:16]; // R14
        end else if (a == OFS_STACK_PTR) begin
            rd_word[BIT_FULL] = s.full; // R22
            rd_word[BIT_UNF] = s.unf; // R22
            rd_word[SP_W-1:0] = s.sp; // R15
        end
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CNT_LOW) || (a == OFS_HIGH_LATCH) ||
                 (a == OFS_UPPER_LATCH) || (a == OFS_TOP_LOW) ||
                 (a == OFS_TOP_HIGH) || (a == OFS_TOP_UPPER) ||
                 (a == OFS_STACK_PTR);
    endfunction

    always_comb begin
        logic apb_done;
        logic wr_ok;
        logic is_push;
        logic is_pop;
        logic stk_rst;
        logic [SP_W-1:0] p;
        logic [SP_W-1:0] p1;
        apb_done = 1'b0;
        wr_ok = 1'b0;
        is_push = 1'b0;
        is_pop = 1'b0;
        stk_rst = 1'b0;
        p = '0;
        p1 = '0;
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        st_nxt.dev_rst = 1'b0;
        // Beyond implemented memory reads as no-operation
        st_nxt.instr = ({1'b0, st_r.pc} < MEM_BYTES) ?
                       I_PROG_DATA : 16'h0000; // R2

        // Answer one cycle into the access phase
        apb_done = I_PSEL & I_PENABLE & st_r.pready;
        if (I_PSEL && I_PENABLE && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = ~mapped(I_PADDR);
            st_nxt.prdata = I_PWRITE ? 32'h0000_0000 :
                            rd_word(I_PADDR, st_r);
        end
        wr_ok = apb_done & I_PWRITE & I_PSTRB[0];

        if (wr_ok) begin
            if (I_PADDR == OFS_CNT_LOW) begin
                st_nxt.pc = {st_r.upper_latch, st_r.high_latch,
                             I_PWDATA[7:1], 1'b0}; // R4 R5 R7
            end else if (I_PADDR == OFS_HIGH_LATCH) begin
                st_nxt.high_latch = I_PWDATA[7:0]; // R4
            end else if (I_PADDR == OFS_UPPER_LATCH) begin
                st_nxt.upper_latch = I_PWDATA[4:0]; // R4
            end else if (I_PADDR == OFS_TOP_LOW) begin
                if (st_r.sp != SP_RST) begin
                    st_nxt.stk[st_r.sp][7:0] = I_PWDATA[7:0]; // R14
                end
            end else if (I_PADDR == OFS_TOP_HIGH) begin
                if (st_r.sp != SP_RST) begin
                    st_nxt.stk[st_r.sp][15:8] = I_PWDATA[7:0]; // R14
                end
            end else if (I_PADDR == OFS_TOP_UPPER) begin
                if (st_r.sp != SP_RST) begin
                    st_nxt.stk[st_r.sp][20:16] = I_PWDATA[4:0]; // R14
                end
            end else if (I_PADDR == OFS_STACK_PTR) begin
                st_nxt.sp = I_PWDATA[SP_W-1:0]; // R15 R22
                if (!I_PWDATA[BIT_FULL]) begin
                    st_nxt.full = 1'b0; // R24
                end
                if (!I_PWDATA[BIT_UNF]) begin
                    st_nxt.unf = 1'b0; // R24
                end
            end
        end
        if (apb_done && !I_PWRITE && I_PADDR == OFS_CNT_LOW) begin
            st_nxt.high_latch = st_r.pc[15:8]; // R6
            st_nxt.upper_latch = st_r.pc[20:16]; // R6
        end

        // Core operation lands after software, so its flag sets win
        is_push = (I_CMD.op == OP_CALL) || (I_CMD.op == OP_RELATIVE_SUBROUTINE_JUMP) ||
                  (I_CMD.op == OP_INT_HI) || (I_CMD.op == OP_INT_LO) ||
                  (I_CMD.op == OP_PUSH); // R9 R21
        is_pop = (I_CMD.op == OP_RETURN) || (I_CMD.op == OP_RET_LIT) ||
                 (I_CMD.op == OP_RET_INT) || (I_CMD.op == OP_POP) ||
                 ((I_CMD.op == OP_UNLINK) && I_EXT_EN); // R9
        p = st_nxt.sp;
        p1 = p + 5'h01;

        if (is_push) begin
            if (p == SP_MAX) begin
                // Overflowed: entry 31 is kept intact
                st_nxt.full = 1'b1; // R18
                stk_rst = I_OVF_RST_EN; // R20
            end else begin
                st_nxt.stk[p1] = st_r.pc; // R11 R12 R17
                st_nxt.sp = p1; // R12 R18
                if (p1 == SP_MAX) begin
                    st_nxt.full = 1'b1; // R16
                    stk_rst = I_OVF_RST_EN; // R17 R20
                end
            end
        end else if (is_pop) begin
            if (p == SP_RST) begin
                st_nxt.unf = 1'b1; // R19
                if (I_CMD.op != OP_POP) begin
                    st_nxt.pc = VEC_RESET; // R19
                end
                stk_rst = I_OVF_RST_EN; // R20
            end else begin
                if (I_CMD.op != OP_POP) begin
                    st_nxt.pc = st_nxt.stk[p]; // R12
                end
                st_nxt.sp = p - 5'h01; // R12 R21
            end
        end

        // Latches are never touched here
        case (I_CMD.op) // R10
            OP_SEQ: begin
                st_nxt.pc = st_r.pc + PC_STEP; // R7
            end
            OP_CALL, OP_RELATIVE_SUBROUTINE_JUMP, OP_JUMP, OP_BRANCH: begin
                st_nxt.pc = {I_CMD.target[20:1], 1'b0}; // R8
            end
            OP_INT_HI: begin
                st_nxt.pc = VEC_INT_HI; // R3
            end
            OP_INT_LO: begin
                st_nxt.pc = VEC_INT_LO; // R3
            end
            default: begin
            end
        endcase

        // Device resets keep the flags; power-on reset and software flag writes clear them
        if (stk_rst || I_DEV_RESET) begin
            st_nxt.pc = VEC_RESET; // R3
            st_nxt.sp = SP_RST; // R13 R17
        end
        st_nxt.dev_rst = stk_rst; // R17 R20
        st_nxt.pc[0] = 1'b0; // R7
    end

    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            st_r <= '0; // R3 R13
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_PREADY = st_r.pready;
    assign O_PSLVERR = st_r.pslverr;
    assign O_PRDATA = st_r.prdata;
    assign O_FETCH_ADDR = st_r.pc; // R1
    assign O_INSTR = st_r.instr;
    assign O_STACK_RESET = st_r.dev_rst;
    assign O_FULL = st_r.full;
    assign O_UNF = st_r.unf;
endmodule

// >>> pcrs_prog_model.sv
`timescale 1ns/100ps
module pcrs_prog_model (
    input wire logic [20:0] i_addr, // Fetch address
    output logic [15:0] o_data      // Program word
);
    // Word index as content, so every fetch is traceable
    assign o_data = i_addr[16:1];
endmodule

// >>> pcrs_assertions.sv
`timescale 1ns/100ps
module pcrs_assertions
    import pcrs_pkg::*;
#(
    parameter logic [21:0] MEM_BYTES = MEM_BYTES_DEF
) (
    input wire logic I_MCLK,              // Clock
    input wire logic I_RESET,             // Power-on reset
    input wire logic I_DEV_RESET,         // Device reset
    input wire logic I_OVF_RST_EN,        // Overflow reset
    input wire pcrs_pkg::pcrs_cmd_t I_CMD, // Command
    input wire logic [15:0] I_PROG_DATA,  // Program word
    input wire logic I_PSEL,              // APB select
    input wire logic [20:0] O_FETCH_ADDR, // Counter
    input wire logic [15:0] O_INSTR,      // Fetched word
    input wire logic O_STACK_RESET,       // Reset pulse
    input wire logic O_FULL,              // Full flag
    input wire logic O_UNF                // Underflow flag
);
    logic quiet;
    // APB may rewrite the counter, so skip cycles with a select
    assign quiet = !I_PSEL && !I_DEV_RESET;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);
    chk_word_align: assert property (O_FETCH_ADDR[0] == 1'b0)
        else $error("Fetch address odd");
    chk_seq_step: assert property (quiet && I_CMD.op == OP_SEQ
        |=> O_FETCH_ADDR == $past(O_FETCH_ADDR) + PC_STEP)
        else $error("Sequential step wrong");
    chk_direct_load: assert property (quiet
        && I_CMD.op inside {OP_JUMP, OP_BRANCH}
        |=> O_FETCH_ADDR == {$past(I_CMD.target[20:1]), 1'b0})
        else $error("Jump target not loaded");
    chk_int_vector: assert property (quiet && !I_OVF_RST_EN
        && I_CMD.op inside {OP_INT_HI, OP_INT_LO}
        |=> O_FETCH_ADDR == ($past(I_CMD.op) == OP_INT_HI ?
        VEC_INT_HI : VEC_INT_LO))
        else $error("Interrupt vector wrong");
    chk_dev_reset: assert property (I_DEV_RESET
        |=> O_FETCH_ADDR == VEC_RESET)
        else $error("Device reset missed");
    chk_full_sticky: assert property (O_FULL && !I_PSEL |=> O_FULL)
        else $error("Full flag lost");
    chk_unf_sticky: assert property (O_UNF && !I_PSEL |=> O_UNF)
        else $error("Underflow flag lost");
    chk_stack_reset: assert property ($rose(O_STACK_RESET)
        |-> $past(I_OVF_RST_EN) && (O_FULL || O_UNF)
        && O_FETCH_ADDR == VEC_RESET ##1 !O_STACK_RESET)
        else $error("Stack reset wrong");
    chk_instr_zero: assert property (!$past(I_RESET)
        |-> O_INSTR == ($past(O_FETCH_ADDR) >= MEM_BYTES ?
        16'h0000 : $past(I_PROG_DATA)))
        else $error("Fetched word wrong");
endmodule

bind pcrs_top pcrs_assertions #(.MEM_BYTES(MEM_BYTES)) u_chk (
    .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_DEV_RESET(I_DEV_RESET),
    .I_OVF_RST_EN(I_OVF_RST_EN), .I_CMD(I_CMD), .I_PSEL(I_PSEL),
    .I_PROG_DATA(I_PROG_DATA), .O_FETCH_ADDR(O_FETCH_ADDR),
    .O_INSTR(O_INSTR), .O_STACK_RESET(O_STACK_RESET),
    .O_FULL(O_FULL), .O_UNF(O_UNF));

// >>> pcrs_top_test.sv
`timescale 1ns/100ps
module pcrs_top_test;
    import pcrs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dev_rst = 1'b0;
    logic ovf_en = 1'b0;
    logic ext_en = 1'b1;
    pcrs_cmd_t cmd = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] prog, instr;
    logic pready, pslverr, full, unf, stk_rst, err;
    logic [31:0] prdata, rd;
    logic [20:0] fetch;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    pcrs_op_t push_ops [4] = '{OP_CALL, OP_RELATIVE_SUBROUTINE_JUMP, OP_INT_HI, OP_INT_LO};
    pcrs_op_t pop_ops [4] = '{OP_RETURN, OP_RET_LIT, OP_RET_INT, OP_UNLINK};
    logic [20:0] push_exp [4] = '{21'h200, 21'h200, VEC_INT_HI, VEC_INT_LO};
    always #10 clk = ~clk;
    pcrs_top #(.MEM_BYTES(22'h000100)) dut (
        .I_MCLK(clk), .I_RESET(rst), .I_DEV_RESET(dev_rst),
        .I_OVF_RST_EN(ovf_en), .I_EXT_EN(ext_en), .I_CMD(cmd),
        .I_PROG_DATA(prog), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_PSTRB(4'hF), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_PRDATA(prdata), .O_FETCH_ADDR(fetch), .O_INSTR(instr),
        .O_STACK_RESET(stk_rst), .O_FULL(full), .O_UNF(unf));
    pcrs_prog_model pmem (.i_addr(fetch), .o_data(prog));
    task automatic end_sim();
        $display("Checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never answers
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic op(input pcrs_op_t o, input logic [20:0] t);
        @(posedge clk);
        cmd <= '{op: o, target: t};
        @(posedge clk);
        cmd <= '{op: OP_NONE, target: 21'h0};
        #1;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdchk(OFS_STACK_PTR, 32'h0);
        rdchk(OFS_CNT_LOW, 32'h0);
        repeat (3) op(OP_SEQ, 21'h0);
        chk(fetch, 32'h6);
        @(posedge clk);
        #1 chk(instr, 32'h3);
        op(OP_JUMP, 21'h1FFFFF);
        chk(fetch, 32'h1FFFFE);
        @(posedge clk);
        #1 chk(instr, 32'h0);
        op(OP_BRANCH, 21'h000011);
        chk(fetch, 32'h10);
        $display("Test fetch done");
        apb(1'b1, OFS_HIGH_LATCH, 32'h12);
        apb(1'b1, OFS_UPPER_LATCH, 32'h03);
        apb(1'b1, OFS_CNT_LOW, 32'h35);
        #1 chk(fetch, 32'h031234);
        op(OP_JUMP, 21'h0ABCD0);
        rdchk(OFS_CNT_LOW, 32'hD0);
        rdchk(OFS_HIGH_LATCH, 32'hBC);
        rdchk(OFS_UPPER_LATCH, 32'h0A);
        $display("Test latch done");
        // No interrupt op while software edits the stack
        for (int i = 0; i < 4; i++) begin
            op(OP_JUMP, 21'h000040);
            op(push_ops[i], 21'h000200);
            chk(fetch, push_exp[i]);
            rdchk(OFS_STACK_PTR, 32'h1);
            rdchk(OFS_TOP_LOW, 32'h40);
            op(pop_ops[i], 21'h0);
            chk(fetch, 32'h40);
            rdchk(OFS_STACK_PTR, 32'h0);
        end
        rdchk(OFS_HIGH_LATCH, 32'hBC);
        op(OP_CALL, 21'h000200);
        apb(1'b1, OFS_TOP_LOW, 32'h60);
        op(OP_RETURN, 21'h0);
        chk(fetch, 32'h60);
        op(OP_SEQ, 21'h0);
        op(OP_PUSH, 21'h0);
        rdchk(OFS_TOP_LOW, 32'h62);
        op(OP_POP, 21'h0);
        chk(fetch, 32'h62);
        rdchk(OFS_STACK_PTR, 32'h0);
        $display("Test stack done");
        apb(1'b1, OFS_STACK_PTR, 32'h1E);
        repeat (2) op(OP_PUSH, 21'h0);
        rdchk(OFS_STACK_PTR, 32'h9F);
        chk({full, unf}, 32'h2);
        apb(1'b1, OFS_STACK_PTR, 32'h9E);
        rdchk(OFS_STACK_PTR, 32'h9E);
        apb(1'b1, OFS_STACK_PTR, 32'h20);
        rdchk(OFS_STACK_PTR, 32'h00);
        op(OP_RETURN, 21'h0);
        chk(fetch, 32'h0);
        rdchk(OFS_STACK_PTR, 32'h40);
        chk({full, unf}, 32'h1);
        $display("Test flags done");
        ovf_en <= 1'b1;
        apb(1'b1, OFS_STACK_PTR, 32'h1E);
        op(OP_JUMP, 21'h000044);
        op(OP_PUSH, 21'h0);
        chk(stk_rst, 32'h1);
        @(posedge clk);
        #1 chk(fetch, 32'h0);
        chk(stk_rst, 32'h0);
        rdchk(OFS_STACK_PTR, 32'h80);
        op(OP_POP, 21'h0);
        rdchk(OFS_STACK_PTR, 32'hC0);
        apb(1'b1, OFS_STACK_PTR, 32'hC3);
        op(OP_JUMP, 21'h000080);
        @(posedge clk);
        dev_rst <= 1'b1;
        @(posedge clk);
        dev_rst <= 1'b0;
        #1 chk(fetch, 32'h0);
        rdchk(OFS_STACK_PTR, 32'hC0);
        ext_en <= 1'b0;
        op(OP_CALL, 21'h000200);
        op(OP_UNLINK, 21'h0);
        chk(fetch, 32'h200);
        apb(1'b0, 8'h1C, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("Test reset done");
        end_sim();
    end
endmodule
